/* File: include/nvmsr_params.svh */
// Timing counts and widths for the nonvolatile SRAM host controller
`ifndef NVMSR_PARAMS_SVH
`define NVMSR_PARAMS_SVH
`define NVMSR_CLK_MHZ 40
`define NVMSR_ADDR_W 9
`define NVMSR_DATA_W 8
// Access phase time in ns, then cycles rounded up
`define NVMSR_ACCESS_NS 50
`define NVMSR_ACCESS_CYC ((`NVMSR_ACCESS_NS * `NVMSR_CLK_MHZ + 999) / 1000)
// Nonvolatile initiation hold in ns
`define NVMSR_INIT_NS 20
`define NVMSR_INIT_CYC ((`NVMSR_INIT_NS * `NVMSR_CLK_MHZ + 999) / 1000)
// Longest store in ms, longest recall in us, power-up reload in us
`define NVMSR_STORE_MS 10
`define NVMSR_STORE_CYC (`NVMSR_STORE_MS * `NVMSR_CLK_MHZ * 1000)
`define NVMSR_RECALL_US 20
`define NVMSR_RECALL_CYC (`NVMSR_RECALL_US * `NVMSR_CLK_MHZ)
`define NVMSR_RELOAD_US 550
`define NVMSR_RELOAD_CYC (`NVMSR_RELOAD_US * `NVMSR_CLK_MHZ)
`define NVMSR_CNT_W 20
`endif

/* File: include/nvmsr_pkg.sv */
// Types for the nonvolatile SRAM host controller
package nvmsr_pkg;
  typedef enum logic [2:0] {
    NVMSR_CMD_READ = 3'h0,
    NVMSR_CMD_WRITE = 3'h1,
    NVMSR_CMD_STORE = 3'h2,
    NVMSR_CMD_RECALL = 3'h3
  } nvmsr_cmd_type;
  // Active-low strobes toward the memory
  typedef struct packed {
    logic chip_sel_n;
    logic write_n;
    logic out_gate_n;
    logic nonvolatile_xfer_n;
  } nvmsr_strobe_type;
  typedef enum logic [6:0] {
    NVMSR_ST_BOOT = 7'h01,
    NVMSR_ST_IDLE = 7'h02,
    NVMSR_ST_SETUP = 7'h04,
    NVMSR_ST_ACCESS = 7'h08,
    NVMSR_ST_INIT = 7'h10,
    NVMSR_ST_WAIT = 7'h20,
    NVMSR_ST_END = 7'h40
  } nvmsr_state_type;
endpackage

/* File: rtl/nvmsr_host.sv */
// Host controller driving the strobes, address and data of a nonvolatile SRAM
// Functional notes
// - Host holds write strobe high in reads and low in writes.
// - Host keeps transfer strobe high throughout ordinary reads and writes.
// - Host ends initiation by raising all strobes at once; memory accepts it.
// - For a write-started store, gate is already high when transfer falls.
`include "nvmsr_params.svh"
module nvmsr_host
  import nvmsr_pkg::*;
#(
  parameter int unsigned STORE_CYC = `NVMSR_STORE_CYC,
  parameter int unsigned RECALL_CYC = `NVMSR_RECALL_CYC,
  parameter int unsigned RELOAD_CYC = `NVMSR_RELOAD_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire nvmsr_cmd_type req_cmd,
  input wire logic [`NVMSR_ADDR_W-1:0] req_addr,
  input wire logic [`NVMSR_DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`NVMSR_DATA_W-1:0] rsp_rdata,
  output nvmsr_strobe_type mem_strobe,
  output logic [`NVMSR_ADDR_W-1:0] mem_addr,
  output logic [`NVMSR_DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe_n,
  input wire logic [`NVMSR_DATA_W-1:0] mem_dq_in
);
  localparam logic [`NVMSR_CNT_W-1:0] ACC_N = `NVMSR_CNT_W'(`NVMSR_ACCESS_CYC);
  localparam logic [`NVMSR_CNT_W-1:0] INIT_N = `NVMSR_CNT_W'(`NVMSR_INIT_CYC);
  localparam nvmsr_strobe_type IDLE_STB = '{1'b1, 1'b1, 1'b1, 1'b1};

  nvmsr_state_type state_reg;
  nvmsr_cmd_type cmd_reg;
  logic [`NVMSR_CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= NVMSR_ST_BOOT;
      cnt_reg <= `NVMSR_CNT_W'(RELOAD_CYC);
      cmd_reg <= NVMSR_CMD_READ;
      mem_strobe <= IDLE_STB;
      mem_addr <= '0;
      mem_dq_out <= '0;
      mem_dq_oe_n <= 1'b1;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        NVMSR_ST_BOOT: begin
          if (cnt_reg <= `NVMSR_CNT_W'(1)) begin
            state_reg <= NVMSR_ST_IDLE;
            req_ready <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - `NVMSR_CNT_W'(1);
          end
        end
        NVMSR_ST_IDLE: begin
          if (req_valid) begin
            req_ready <= 1'b0;
            cmd_reg <= req_cmd;
            mem_addr <= req_addr;
            mem_dq_out <= req_wdata;
            // Address settles one cycle before any strobe
            state_reg <= NVMSR_ST_SETUP;
          end
        end
        NVMSR_ST_SETUP: begin
          cnt_reg <= ACC_N;
          case (cmd_reg)
            NVMSR_CMD_READ: begin
              // Read selection, write and transfer high
              mem_strobe <= '{1'b0, 1'b1, 1'b0, 1'b1};
              state_reg <= NVMSR_ST_ACCESS;
            end
            NVMSR_CMD_WRITE: begin
              // Gate kept high to avoid bus contention
              mem_strobe <= '{1'b0, 1'b0, 1'b1, 1'b1};
              mem_dq_oe_n <= 1'b0;
              state_reg <= NVMSR_ST_ACCESS;
            end
            NVMSR_CMD_STORE: begin
              // Gate high, transfer and select low; write falls last
              mem_strobe <= '{1'b0, 1'b1, 1'b1, 1'b0};
              // One extra cycle: the first only lowers the write strobe
              cnt_reg <= INIT_N + `NVMSR_CNT_W'(1);
              state_reg <= NVMSR_ST_INIT;
            end
            default: begin
              mem_strobe <= '{1'b0, 1'b1, 1'b0, 1'b0};
              cnt_reg <= INIT_N;
              state_reg <= NVMSR_ST_INIT;
            end
          endcase
        end
        NVMSR_ST_ACCESS: begin
          if (cnt_reg <= `NVMSR_CNT_W'(1)) begin
            // Data still driven as write strobe rises
            if (cmd_reg == NVMSR_CMD_READ) begin
              rsp_rdata <= mem_dq_in;
            end
            mem_strobe <= IDLE_STB;
            state_reg <= NVMSR_ST_END;
          end else begin
            cnt_reg <= cnt_reg - `NVMSR_CNT_W'(1);
          end
        end
        NVMSR_ST_INIT: begin
          // Hold selection the initiation time, then release
          if (cnt_reg <= `NVMSR_CNT_W'(1)) begin
            mem_strobe <= IDLE_STB;
            cnt_reg <= (cmd_reg == NVMSR_CMD_STORE) ? `NVMSR_CNT_W'(STORE_CYC)
                                                    : `NVMSR_CNT_W'(RECALL_CYC);
            state_reg <= NVMSR_ST_WAIT;
          end else begin
            // Write strobe falls last, completing the store selection
            if (cmd_reg == NVMSR_CMD_STORE) begin
              mem_strobe.write_n <= 1'b0;
            end
            cnt_reg <= cnt_reg - `NVMSR_CNT_W'(1);
          end
        end
        NVMSR_ST_WAIT: begin
          // Idle strobes for the longest cycle time
          if (cnt_reg <= `NVMSR_CNT_W'(1)) begin
            state_reg <= NVMSR_ST_END;
          end else begin
            cnt_reg <= cnt_reg - `NVMSR_CNT_W'(1);
          end
        end
        default: begin
          mem_dq_oe_n <= 1'b1;
          rsp_valid <= 1'b1;
          req_ready <= 1'b1;
          state_reg <= NVMSR_ST_IDLE;
        end
      endcase
    end
  end

  // Write strobe matches the access kind
  a_write_level: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == NVMSR_ST_ACCESS) |-> (mem_strobe.write_n == (cmd_reg != NVMSR_CMD_WRITE)))
    else $error("write strobe wrong during access");
  // Transfer strobe high in ordinary access
  a_xfer_high: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == NVMSR_ST_ACCESS) |-> mem_strobe.nonvolatile_xfer_n)
    else $error("transfer strobe low in access");
  a_boot_idle: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == NVMSR_ST_BOOT) |-> (mem_strobe.chip_sel_n && !req_ready))
    else $error("access during reload");
  // Data driven while the write strobe is low and transfer is high
  a_write_data: assert property (@(posedge clk) disable iff (sys_rst)
    !mem_strobe.write_n && mem_strobe.nonvolatile_xfer_n |-> !mem_dq_oe_n)
    else $error("write without data drive");
  // Gate high whenever store selection stands
  a_store_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (!mem_strobe.nonvolatile_xfer_n && cmd_reg == NVMSR_CMD_STORE) |-> mem_strobe.out_gate_n)
    else $error("gate low during store start");
  // Initiation ends with all strobes high
  a_init_end: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == NVMSR_ST_INIT) ##1 (state_reg == NVMSR_ST_WAIT) |-> (mem_strobe == IDLE_STB))
    else $error("strobes held after initiation");
  a_wait_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == NVMSR_ST_WAIT) |-> (mem_strobe == IDLE_STB && mem_dq_oe_n))
    else $error("activity during store or recall");
  // Response follows a deselected end cycle
  a_resp_end: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == NVMSR_ST_END) |=> (rsp_valid && req_ready && mem_strobe.chip_sel_n))
    else $error("end cycle response missing");
  // Write and transfer low only inside a full store selection
  a_store_select: assert property (@(posedge clk) disable iff (sys_rst)
    (!mem_strobe.write_n && !mem_strobe.nonvolatile_xfer_n) |-> (!mem_strobe.chip_sel_n && mem_strobe.out_gate_n))
    else $error("incomplete store selection");
  // Full selection stood just before the transfer strobe rises
  a_init_hold: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(mem_strobe.nonvolatile_xfer_n) |-> ($past(mem_strobe) == ((cmd_reg == NVMSR_CMD_STORE) ? 4'b0010 : 4'b0100)))
    else $error("initiation not held");
  // Data still driven when the write strobe rises
  a_write_end: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_reg == NVMSR_CMD_WRITE && $rose(mem_strobe.write_n)) |-> !mem_dq_oe_n)
    else $error("data released before write end");
  a_ready_idle: assert property (@(posedge clk) disable iff (sys_rst)
    req_ready |-> (mem_strobe == IDLE_STB && mem_dq_oe_n))
    else $error("ready while memory selected");
  // No host drive while the memory answers a read
  a_read_nodrive: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == NVMSR_ST_ACCESS && cmd_reg == NVMSR_CMD_READ) |-> mem_dq_oe_n)
    else $error("host drives data in read");
  // Gate and transfer low only with write strobe high
  a_recall_write: assert property (@(posedge clk) disable iff (sys_rst)
    (!mem_strobe.out_gate_n && !mem_strobe.nonvolatile_xfer_n) |-> mem_strobe.write_n)
    else $error("write low in recall selection");
  a_rsp_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  // Address and data steady while selected
  a_addr_stable: assert property (@(posedge clk) disable iff (sys_rst)
    !mem_strobe.chip_sel_n |-> ($stable(mem_addr) && $stable(mem_dq_out)))
    else $error("address or data moved while selected");
endmodule

/* File: tb/nvmsr_mem_model.sv */
// Behavioural nonvolatile SRAM answering the host strobes
module nvmsr_mem_model
  import nvmsr_pkg::*;
#(
  parameter int STORE_NS = 300,
  parameter int RECALL_NS = 150,
  parameter int RELOAD_NS = 200
) (
  input wire nvmsr_strobe_type strobe,
  input wire logic [8:0] addr,
  input wire logic [7:0] host_dq,
  input wire logic host_oe_n,
  output logic [7:0] dq_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sram [512];
  logic [7:0] nv [512];
  logic [7:0] last_q = 8'h00;
  logic busy = 1'b1;
  logic rd_now, wr_now, st_now, rc_now;
  assign rd_now = !busy && strobe == 4'b0101;
  assign wr_now = !busy && !strobe.chip_sel_n && !strobe.write_n && strobe.nonvolatile_xfer_n;
  assign st_now = !busy && strobe == 4'b0010;
  assign rc_now = !busy && strobe == 4'b0100;
  // No pull-up, so a floating bus reads as the inverse
  assign dq_level = !host_oe_n ? host_dq : rd_now ? sram[addr] : ~last_q;
  always @(dq_level) if (!host_oe_n || rd_now) last_q = dq_level;
  initial begin
    for (int i = 0; i < 512; i++) begin
      nv[i] = 8'(i) ^ 8'h5a;
      sram[i] = 8'hff;
    end
    #RELOAD_NS;
    sram = nv;
    busy = 1'b0;
  end
  always @(negedge wr_now) sram[addr] = dq_level;
  always @(posedge st_now) begin
    busy = 1'b1;
    #STORE_NS;
    nv = sram;
    busy = 1'b0;
  end
  always @(posedge rc_now) begin
    busy = 1'b1;
    sram = '{default: 8'h00};
    #RECALL_NS;
    sram = nv;
    busy = 1'b0;
  end
endmodule

/* File: tb/nvmsr_host_tb.sv */
// Self-checking bench for the nonvolatile SRAM host controller
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
    end \
  end
module nvmsr_host_tb
  import nvmsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  nvmsr_cmd_type req_cmd = NVMSR_CMD_READ;
  logic [8:0] req_addr = 9'h000;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, mem_dq_oe_n;
  logic [7:0] rsp_rdata, mem_dq_out, mem_dq_in, d;
  logic [8:0] mem_addr;
  nvmsr_strobe_type mem_strobe;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int lat;
  always #12.5 clk = ~clk;
  nvmsr_host #(.STORE_CYC(20), .RECALL_CYC(10), .RELOAD_CYC(10)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_strobe(mem_strobe), .mem_addr(mem_addr),
    .mem_dq_out(mem_dq_out), .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_in(mem_dq_in));
  nvmsr_mem_model mem_u (.strobe(mem_strobe), .addr(mem_addr), .host_dq(mem_dq_out),
    .host_oe_n(mem_dq_oe_n), .dq_level(mem_dq_in));
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("mismatch at %0t: run hung", $time);
      end_of_test();
    end
  end
  task automatic do_req(input nvmsr_cmd_type cmd, input logic [8:0] a, input logic [7:0] w);
    lat = 0;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd <= cmd;
    req_addr <= a;
    req_wdata <= w;
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(negedge clk);
      lat++;
    end while (rsp_valid !== 1'b1 && lat < 1000);
    `CHK(rsp_valid, 1'b1)
    `CHK(mem_strobe, 4'hf)
    `CHK(mem_dq_oe_n, 1'b1)
    `CHK(mem_addr, a)
    `CHK(mem_dq_out, w)
    d = rsp_rdata;
  endtask
  task automatic t_powerup;
    do_req(NVMSR_CMD_READ, 9'h003, 8'h00);
    `CHK(d, 8'h59)
    $display("power-up test done");
  endtask
  task automatic t_write_read;
    do_req(NVMSR_CMD_WRITE, 9'h1ff, 8'ha5);
    do_req(NVMSR_CMD_WRITE, 9'h000, 8'h3c);
    do_req(NVMSR_CMD_READ, 9'h1ff, 8'h00);
    `CHK(d, 8'ha5)
    do_req(NVMSR_CMD_READ, 9'h000, 8'h00);
    `CHK(d, 8'h3c)
    $display("write read test done");
  endtask
  task automatic t_store_recall;
    do_req(NVMSR_CMD_WRITE, 9'h005, 8'h11);
    do_req(NVMSR_CMD_STORE, 9'h000, 8'h00);
    `CHK(lat > 20, 1'b1)
    do_req(NVMSR_CMD_WRITE, 9'h005, 8'h22);
    // Recall twice: nonvolatile copy must survive the first
    for (int k = 0; k < 2; k++) begin
      do_req(NVMSR_CMD_RECALL, 9'h000, 8'h00);
      do_req(NVMSR_CMD_READ, 9'h005, 8'h00);
      `CHK(d, 8'h11)
    end
    do_req(NVMSR_CMD_READ, 9'h1ff, 8'h00);
    `CHK(d, 8'ha5)
    $display("store recall test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_powerup();
    t_write_read();
    t_store_recall();
    end_of_test();
  end
endmodule
